/* bench/fadc_pipe_asserts.sv */
// checker for the converter output stage
// sees only fadc_pipe ports; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module fadc_pipe_asserts
    import fadc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and results
    input wire logic sample_clock,
    input wire fadc_code_t code_true,
    input wire fadc_code_t code_comp,
    input wire logic overrange_flag,
    input wire logic overrange_flag_n,
    input wire logic code_valid,
    input wire logic sample_dropped
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // an update is only allowed a few cycles behind a sample clock high
    sequence s_code_moved; $changed(code_true); endsequence
    sequence s_after_rise; $past(sample_clock, 3); endsequence
    property p_comp; code_comp == ~code_true; endproperty
    property p_ovfn; overrange_flag_n != overrange_flag; endproperty
    property p_hold; s_code_moved |-> s_after_rise; endproperty
    property p_ovf_upd; $changed(overrange_flag) |-> s_after_rise; endproperty
    property p_top; overrange_flag |-> code_true == 9'h1FF; endproperty
    property p_valid; code_valid |=> code_valid; endproperty
    property p_first; $rose(code_valid) |-> s_after_rise; endproperty
    property p_nodrop; !sample_dropped; endproperty
    a_comp: assert property (p_comp)
        else $error("code pair mismatch");
    a_ovfn: assert property (p_ovfn)
        else $error("flag pair mismatch");
    a_hold: assert property (p_hold) else $error("code moved early");
    a_ovf_upd: assert property (p_ovf_upd) else $error("flag moved");
    a_top: assert property (p_top) else $error("flag without top code");
    a_valid: assert property (p_valid) else $error("valid dropped");
    a_first: assert property (p_first) else $error("valid too early");
    a_nodrop: assert property (p_nodrop) else $error("word lost");
endmodule // fadc_pipe_asserts
bind fadc_pipe fadc_pipe_asserts fadc_pipe_asserts_i (.clk(clk), .rst(rst),
    .sample_clock(sample_clock), .code_true(code_true),
    .code_comp(code_comp), .overrange_flag(overrange_flag),
    .overrange_flag_n(overrange_flag_n), .code_valid(code_valid),
    .sample_dropped(sample_dropped));
`default_nettype wire

/* bench/fadc_pipe_bench.sv */
// bench: level rows through the pipeline, then a mid-run reset
// assumes fadc_pipe, its checker and the partner model
`timescale 1ns/1ps
`default_nettype none
module fadc_pipe_bench
    import fadc_pkg::*;
;
    logic clk, rst, sample_clock, sample_clock_n, overrange_flag;
    logic overrange_flag_n, code_valid, sample_dropped;
    int lvl, n_fail, checks_done, cyc;
    fadc_thermo_t cmp_level;
    fadc_code_t code_true, code_comp;
    fadc_word_t seen;
    // rows: comparator count beside flag and code expected
    int lv_row[7] = '{0, 1, 256, 510, 511, 512, 300};
    fadc_word_t ex_row[7] = '{10'h000, 10'h001, 10'h100, 10'h1FE,
        10'h1FF, 10'h3FF, 10'h12C};
    fadc_pipe fadc_pipe_i (.clk(clk), .rst(rst),
        .sample_clock(sample_clock), .sample_clock_n(sample_clock_n),
        .cmp_level(cmp_level), .code_true(code_true),
        .code_comp(code_comp), .overrange_flag(overrange_flag),
        .overrange_flag_n(overrange_flag_n), .code_valid(code_valid),
        .sample_dropped(sample_dropped));
    fadc_sample_clock_src fadc_sample_clock_src_i (.clk(clk), .lvl(lvl),
        .sample_clock(sample_clock), .sample_clock_n(sample_clock_n),
        .cmp_level(cmp_level));
    task automatic check(string nm, fadc_word_t exp, fadc_word_t got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        lvl = 0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        // a row shows two sample periods after it was set
        for (int i = 0; i < 9; i++) begin
            @(posedge sample_clock);
            if (i < 7) lvl = lv_row[i];
            repeat (4) @(posedge clk);
            #1;
            if (i >= 2) begin
                seen = {overrange_flag, code_true};
                check("code", ex_row[i-2], seen);
                seen = {overrange_flag_n, code_comp};
                check("comp", ~ex_row[i-2], seen);
                check("drop", 10'h000, {9'h000, sample_dropped});
            end
        end
        check("valid", 10'h001, {9'h000, code_valid});
        // reset in mid-run clears the outputs
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 seen = {overrange_flag | code_valid, code_true};
        check("rst", 10'h000, seen);
        seen = {overrange_flag_n, code_comp};
        check("rst_n", 10'h3FF, seen);
        rst = 1'b0;
        lvl = 511;
        repeat (3) @(posedge sample_clock);
        repeat (4) @(posedge clk);
        #1 seen = {overrange_flag, code_true};
        check("again", 10'h1FF, seen);
        conclude();
    end
endmodule // fadc_pipe_bench
`default_nettype wire

/* bench/fadc_sample_clock_src.sv */
// partner: sample clock pair and comparator array
// assumes the bench clock; level count taken at each low phase
`timescale 1ns/1ps
`default_nettype none
module fadc_sample_clock_src
    import fadc_pkg::*;
(
    // clock and level request
    input wire logic clk,
    input wire logic [31:0] lvl,
    // pins toward the block
    output logic sample_clock,
    output logic sample_clock_n,
    output fadc_thermo_t cmp_level
);
    // three cycles low, three high, comparators settled while low
    initial begin
        sample_clock = 1'b0;
        sample_clock_n = 1'b1;
        cmp_level = '0;
        forever begin
            cmp_level = ~('1 << lvl);
            repeat (3) @(posedge clk);
            #1 sample_clock = 1'b1;
            sample_clock_n = 1'b0;
            repeat (3) @(posedge clk);
            #1 sample_clock = 1'b0;
            sample_clock_n = 1'b1;
        end
    end
endmodule // fadc_sample_clock_src
`default_nettype wire

/* logic/fadc_params.svh */
// constants for the flash converter encode and output pipeline
// assumes one 100 MHz clock; included by the package and the design
`ifndef FADC_PARAMS_SVH
`define FADC_PARAMS_SVH
`define FADC_NUM_CMP 512
`define FADC_CODE_W 9
`define FADC_CODE_MAX 9'h1FF
`define FADC_TOP_CMP 511
`define FADC_FIFO_DEPTH 4
`define FADC_FIFO_AW 2
`define FADC_CODE_RST 9'h000
`define FADC_CLK_PERIOD_NS 10
`define FADC_OUTPUT_DELAY_NS 27
`define FADC_OUTPUT_DELAY_CYC \
    ((`FADC_OUTPUT_DELAY_NS / `FADC_CLK_PERIOD_NS) < 1 ? 1 : \
    (`FADC_OUTPUT_DELAY_NS / `FADC_CLK_PERIOD_NS))
`endif

/* logic/fadc_pipe.sv */
// flash converter encode and output pipeline, with its result fifo
// latch on sample clock rise, encode on its fall, load on next rise
// assumes comparator outputs and the sample clock pair arrive from pins
// assumes clk well above the sample clock, each phase two clk or more
// the code counts the active comparators below the top one; the top one feeds the flag
`timescale 1ns/1ps
`default_nettype none
`include "fadc_params.svh"

////////////////////////////////////////////////////////////////////////
// small synchronous fifo, valid/ready on both sides
// storage is plain flops read at the read pointer; depth a power of two
module fadc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // storage and pointers
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    // transfers on each side
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // full and empty from the occupancy count, which is one bit wider
    // than the pointers so that a full fifo does not read as empty;
    // a pop in the same cycle frees a slot for the push
    assign in_ready = (cnt_q != (AW+1)'(DEPTH)) || out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // storage write; no reset needed, as a word is only read after
    // it has been written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            // pointers wrap at DEPTH, a power of two
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            // count moves only when one side acts alone
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // fadc_fifo

////////////////////////////////////////////////////////////////////////
// top: latch, encode and output register
// pin rise to new code is about three clk: two sync flops, then the
// output register; the code shown is always one sample behind
module fadc_pipe
    import fadc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // differential sample clock from the partner
    input wire logic sample_clock,
    input wire logic sample_clock_n,
    // comparator array outputs, bit i set when input above level i
    input wire logic [`FADC_NUM_CMP-1:0] cmp_level,
    // result, true and complement
    output logic [`FADC_CODE_W-1:0] code_true,
    output logic [`FADC_CODE_W-1:0] code_comp,
    output logic overrange_flag,
    output logic overrange_flag_n,
    // status
    output logic code_valid,
    output logic sample_dropped
);
    // synchroniser, latch and fifo state
    fadc_thermo_t cmp_s1_q;
    fadc_thermo_t cmp_s2_q;
    fadc_thermo_t thermo_q;
    logic [1:0] clk_s1_q;
    logic [1:0] clk_s2_q;
    logic sclk_q;
    logic latched_q;
    fadc_word_t enc_d;
    fadc_word_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    // output register
    fadc_code_t code_q;
    logic ovf_q;
    logic valid_q;
    logic drop_q;

    // count of active comparators below the top one; with all 511 on
    // the count is 511, so the top comparator is left to the flag
    function automatic fadc_code_t fadc_count(input fadc_thermo_t t);
        fadc_code_t n;
        n = '0;
        for (int i = 0; i < `FADC_TOP_CMP; i++) begin
            n = n + fadc_code_t'(t[i]);
        end
        return n;
    endfunction

    // two-flop synchronisers for every pin input; the wide comparator
    // bus is sampled only well after the partner last moved it, so its
    // bits cannot be caught half way through a change
    always_ff @(posedge clk) begin
        clk_s1_q <= {sample_clock, sample_clock_n};
        clk_s2_q <= clk_s1_q;
        cmp_s1_q <= cmp_level;
        cmp_s2_q <= cmp_s1_q;
    end

    // clock level is true phase high with complement low
    // a pair caught mid-swap reads low, which only delays the edge
    wire sclk_lvl = clk_s2_q[1] && !clk_s2_q[0];
    wire sclk_rise = sclk_lvl && !sclk_q;
    wire sclk_fall = !sclk_lvl && sclk_q;

    // encoder: count gives 0..511, top comparator gives overrange
    // enc_d is taken at a fall, a phase after the latch settled
    wire fadc_code_t enc_code = fadc_count(thermo_q);
    wire enc_ovf = thermo_q[`FADC_TOP_CMP];
    assign enc_d = {enc_ovf, enc_code};

    // level tracker, not reset: after a reset it already holds the
    // present level, so a reset let go in the high phase makes no
    // false rising edge
    always_ff @(posedge clk) begin
        sclk_q <= sclk_lvl;
    end

    // comparator latch; latched_q says a real sample is held, so the
    // first fall after a reset pushes no stale word
    always_ff @(posedge clk) begin
        if (rst) begin
            thermo_q <= '0;
            latched_q <= 1'b0;
        end else if (sclk_rise) begin
            thermo_q <= cmp_s2_q;
            latched_q <= 1'b1;
        end
    end

    // a fall pushes the word encoded from the sample just latched
    wire push_req = sclk_fall && latched_q;

    // encoded words wait here until the next rising edge; with the
    // clock alternating the fifo holds one word, the rest is slack
    fadc_fifo #(
        .WIDTH(`FADC_CODE_W + 1),
        .DEPTH(`FADC_FIFO_DEPTH),
        .AW(`FADC_FIFO_AW)
    ) fadc_fifo_i (
        .clk(clk),
        .rst(rst),
        .in_valid(push_req),
        .in_ready(fifo_in_ready),
        .in_data(enc_d),
        .out_valid(fifo_out_valid),
        .out_ready(sclk_rise),
        .out_data(fifo_out)
    );

    // output register, loaded only on a rising edge; a rise that finds
    // the fifo empty leaves the outputs as they are, and a word that
    // cannot enter a full fifo is reported by a one-cycle pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            code_q <= `FADC_CODE_RST;
            ovf_q <= 1'b0;
            valid_q <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            drop_q <= push_req && !fifo_in_ready;
            // the flag rides in the same word as its code
            if (sclk_rise && fifo_out_valid) begin
                code_q <= fifo_out[`FADC_CODE_W-1:0];
                ovf_q <= fifo_out[`FADC_CODE_W];
                valid_q <= 1'b1;
            end
        end
    end

    // true and complement pairs; capture logic picks the polarity of
    // each bit to suit the number format it wants
    assign code_true = code_q;
    assign code_comp = ~code_q;
    // the flag travels as a pair as well
    assign overrange_flag = ovf_q;
    assign overrange_flag_n = ~ovf_q;
    // status outputs
    assign code_valid = valid_q;
    assign sample_dropped = drop_q;
endmodule // fadc_pipe
`default_nettype wire

/* logic/fadc_pkg.sv */
// types shared by the converter back end
// assumes fadc_params.svh on the include path
`default_nettype none
`include "fadc_params.svh"
package fadc_pkg;
    typedef logic [`FADC_NUM_CMP-1:0] fadc_thermo_t;
    typedef logic [`FADC_CODE_W-1:0] fadc_code_t;
    // fifo word: overrange flag on top of the code
    typedef logic [`FADC_CODE_W:0] fadc_word_t;
endpackage
`default_nettype wire
